// [src/sadt_pkg.sv]
// shared constants, types and state layout for the arbitration and dma termination block
package sadt_pkg;
    // clock and bus-phase timing
    localparam int CLK_NS          = 5;
    localparam int BUS_FREE_MIN_NS = 400;
    localparam int BUS_FREE_MAX_NS = 1200;
    localparam int BUS_FREE_NOM_NS = 800;
    localparam int ARB_EXTRA_NS    = 900;
    localparam int ARB_MIN_NS      = 1200;
    localparam int ARB_MAX_NS      = 2200;
    localparam int FREE_CYC_DEF    = (BUS_FREE_NOM_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXTRA_CYC_DEF   = (ARB_EXTRA_NS + CLK_NS - 1) / CLK_NS;
    localparam int ARB_MIN_CYC     = (ARB_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ARB_MAX_CYC     = ARB_MAX_NS / CLK_NS;
    localparam int CNT_W           = 9;

    // register indices, byte address is four times the index
    localparam logic [2:0] IDX_DATA   = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_MODE   = 3'h2;
    localparam logic [2:0] IDX_TCMD   = 3'h3;
    localparam logic [2:0] IDX_START  = 3'h4;
    localparam logic [2:0] IDX_IRQ    = 3'h5;

    // field positions
    localparam int ST_AIP_BIT   = 6;
    localparam int MD_ARB_BIT   = 0;
    localparam int MD_DMA_BIT   = 1;
    localparam int MD_BLK_BIT   = 2;
    localparam int MD_SEND_BIT  = 3;
    localparam int MD_LOST_BIT  = 7;
    localparam int TC_LAST_BIT  = 7;
    localparam int IRQ_MM_BIT   = 0;
    localparam int IRQ_RSL_BIT  = 1;

    typedef enum logic [2:0] {
        ARB_IDLE  = 3'b000,
        ARB_FREE  = 3'b001,
        ARB_DELAY = 3'b010,
        ARB_DRIVE = 3'b011,
        ARB_LOST  = 3'b100
    } sadt_arb_t;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_WAIT = 2'b01,
        XF_ACK  = 2'b10
    } sadt_xfr_t;

    typedef struct packed {
        sadt_arb_t        arb;
        sadt_xfr_t        xfr;
        logic [CNT_W-1:0] cnt;
        logic             arbitrate;
        logic             aip;
        logic             lost;
        logic             dma_en;
        logic             blockmode;
        logic             send;
        logic [7:0]       own_id;
        logic [7:0]       hold;
        logic             hold_full;
        logic             eot_seen;
        logic             last_sent;
        logic [2:0]       phase_exp;
        logic             irq_mm;
        logic             irq_rsl;
        logic             mm_q;
        logic             strobe_q;
        logic             ack_drv;
        logic             data_drv;
        logic             bsy_drv;
        logic [7:0]       out_data;
        logic             wb_ack;
        logic [7:0]       wb_dat;
    } sadt_state_t;

    localparam sadt_state_t ST_RESET = '{arb: ARB_IDLE, xfr: XF_IDLE, default: '0};
endpackage : sadt_pkg

// [src/sadt_core.sv]
// arbitration sequencer, dma transfer engine with clean termination, wishbone registers
`timescale 1ns/1ps
`default_nettype none
module sadt_core
    import sadt_pkg::*;
#(
    parameter int FREE_CYC  = FREE_CYC_DEF,
    parameter int EXTRA_CYC = EXTRA_CYC_DEF
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        bsy_in,
    input  wire logic        sel_in,
    input  wire logic        req_in,
    input  wire logic [2:0]  phase_in,
    input  wire logic [7:0]  data_in,
    output logic             bsy_out,
    output logic             bsy_oe_n,
    output logic             ack_out,
    output logic             ack_oe_n,
    output logic      [7:0]  data_out,
    output logic             data_oe_n,
    input  wire logic        dma_acknowledge_in,
    input  wire logic        host_read_strobe,
    input  wire logic        host_write_strobe,
    input  wire logic        end_of_transfer_input,
    input  wire logic [7:0]  host_data_in,
    output logic      [7:0]  host_data_out,
    output logic             dma_request_out,
    output logic             ready_out
);

    // free interval inside its limits, total delay inside the arbitration window
    if (FREE_CYC * CLK_NS < BUS_FREE_MIN_NS || FREE_CYC * CLK_NS > BUS_FREE_MAX_NS ||
        (FREE_CYC + EXTRA_CYC) * CLK_NS < ARB_MIN_NS ||
        (FREE_CYC + EXTRA_CYC) * CLK_NS > ARB_MAX_NS ||
        FREE_CYC + EXTRA_CYC >= (1 << CNT_W)) begin : g_bad_timing
        $error("sadt_core: arbitration timing parameters out of range");
    end

    function automatic logic hit(input logic [7:0] adr, input logic [2:0] idx);
        hit = (adr[4:2] == idx) && (adr[7:5] == 3'h0) && (adr[1:0] == 2'h0);
    endfunction : hit

    sadt_state_t s_reg;
    sadt_state_t s_next;

    logic bus_idle;
    logic phase_ok;
    logic req_ok;
    logic strobe;
    logic strobe_rise;
    logic mm_now;
    logic wb_req;
    logic wb_wr;

    assign bus_idle    = !bsy_in && !sel_in;
    assign phase_ok    = (phase_in == s_reg.phase_exp);
    assign req_ok      = req_in && phase_ok;
    assign strobe      = dma_acknowledge_in && (host_read_strobe || host_write_strobe);
    assign strobe_rise = strobe && !s_reg.strobe_q;
    assign mm_now      = req_in && s_reg.dma_en && !phase_ok;
    assign wb_req      = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;
    assign wb_wr       = wb_req && wb_we_i && wb_sel_i[0];

    always_comb begin
        s_next          = s_reg;
        s_next.strobe_q = strobe;
        s_next.mm_q     = mm_now;
        s_next.wb_ack   = wb_req;

        // ---------------- arbitration ----------------
        case (s_reg.arb)
            ARB_IDLE: begin
                s_next.cnt = '0;
                if (s_reg.arbitrate) begin
                    s_next.arb = ARB_FREE;
                end
            end
            ARB_FREE: begin
                if (!bus_idle) begin
                    s_next.cnt = '0;
                end else if (s_reg.cnt == CNT_W'(FREE_CYC - 1)) begin
                    s_next.cnt = '0;
                    s_next.arb = ARB_DELAY;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end
            ARB_DELAY: begin
                if (!bus_idle) begin
                    s_next.cnt = '0;
                    s_next.arb = ARB_FREE;
                end else if (s_reg.cnt == CNT_W'(EXTRA_CYC - 1)) begin
                    s_next.arb      = ARB_DRIVE;
                    s_next.bsy_drv  = 1'b1;
                    s_next.data_drv = 1'b1;
                    s_next.out_data = s_reg.own_id;
                    // in-progress set with the first drive
                    s_next.aip      = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end
            ARB_DRIVE: begin
                if (sel_in) begin
                    s_next.arb      = ARB_LOST;
                    s_next.lost     = 1'b1;
                    // release drivers on the next edge
                    s_next.bsy_drv  = 1'b0;
                    s_next.data_drv = 1'b0;
                end
            end
            ARB_LOST: begin
                s_next.bsy_drv  = 1'b0;
                s_next.data_drv = 1'b0;
            end
            default: begin
                s_next.arb = ARB_IDLE;
            end
        endcase

        // dropping the request ends arbitration and clears its flags
        if (!s_reg.arbitrate && s_reg.arb != ARB_IDLE) begin
            s_next.arb     = ARB_IDLE;
            s_next.aip     = 1'b0;
            s_next.lost    = 1'b0;
            s_next.bsy_drv = 1'b0;
            if (s_reg.arb == ARB_DRIVE || s_reg.arb == ARB_LOST) begin
                s_next.data_drv = 1'b0;
            end
        end

        // ---------------- dma transfer engine ----------------
        case (s_reg.xfr)
            XF_IDLE: begin
                s_next.ack_drv = 1'b0;
            end
            XF_WAIT: begin
                // phase mismatch blocks REQ recognition and keeps drivers off
                if (req_ok && s_reg.send && s_reg.hold_full) begin
                    s_next.out_data = s_reg.hold;
                    s_next.data_drv = 1'b1;
                    s_next.ack_drv  = 1'b1;
                    s_next.xfr      = XF_ACK;
                end else if (req_ok && !s_reg.send && !s_reg.hold_full) begin
                    s_next.hold      = data_in;
                    s_next.hold_full = 1'b1;
                    s_next.ack_drv   = 1'b1;
                    s_next.xfr       = XF_ACK;
                end
            end
            XF_ACK: begin
                if (!req_in) begin
                    // ack drops by itself, final byte too
                    s_next.ack_drv = 1'b0;
                    if (s_reg.send) begin
                        // holding register frees only after the bus handshake
                        s_next.hold_full = 1'b0;
                        s_next.data_drv  = 1'b0;
                    end
                    if (s_reg.eot_seen) begin
                        s_next.xfr = XF_IDLE;
                        if (s_reg.send) begin
                            s_next.last_sent = 1'b1;
                        end
                    end else begin
                        s_next.xfr = XF_WAIT;
                    end
                end
            end
            default: begin
                s_next.xfr = XF_IDLE;
            end
        endcase

        // host side of the dma transfer, one byte per strobe
        if (strobe_rise && s_reg.xfr != XF_IDLE && !s_reg.eot_seen) begin
            if (s_reg.send && host_write_strobe && !s_reg.hold_full) begin
                // a byte is taken only into an empty holding register
                s_next.hold      = host_data_in;
                s_next.hold_full = 1'b1;
                // end of transfer counts only with the last strobe
                s_next.eot_seen  = end_of_transfer_input;
            end else if (!s_reg.send && host_read_strobe && s_reg.hold_full) begin
                s_next.hold_full = 1'b0;
                if (end_of_transfer_input) begin
                    s_next.eot_seen = 1'b1;
                    if (s_reg.xfr == XF_WAIT) begin
                        s_next.xfr = XF_IDLE;
                    end
                end
            end
        end

        // transfer data driver follows BSY, dropped one edge after it goes false
        if (!bsy_in && s_reg.arb != ARB_DRIVE && s_reg.arb != ARB_DELAY) begin
            s_next.data_drv = 1'b0;
        end

        // edge capture, whichever of REQ, enable or phase mismatch came later
        if (mm_now && !s_reg.mm_q) begin
            s_next.irq_mm = 1'b1;
        end
        // only selection sets it; phase disagreement never clears it
        if (sel_in && !bsy_in && phase_in[0] && |(data_in & s_reg.own_id)) begin
            s_next.irq_rsl = 1'b1;
        end

        // ---------------- register writes ----------------
        if (wb_wr) begin
            if (hit(wb_adr_i, IDX_DATA)) begin
                s_next.own_id = wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, IDX_MODE)) begin
                s_next.arbitrate = wb_dat_i[MD_ARB_BIT];
                s_next.blockmode = wb_dat_i[MD_BLK_BIT];
                s_next.send      = wb_dat_i[MD_SEND_BIT];
                // enable only accepted with BSY active, clearing always
                s_next.dma_en    = wb_dat_i[MD_DMA_BIT] && (bsy_in || s_reg.dma_en);
                if (!wb_dat_i[MD_DMA_BIT]) begin
                    // hard stop; a received byte stays readable
                    s_next.xfr      = XF_IDLE;
                    s_next.ack_drv  = 1'b0;
                    s_next.eot_seen = 1'b0;
                end
            end
            if (hit(wb_adr_i, IDX_TCMD)) begin
                s_next.phase_exp = wb_dat_i[2:0];
            end
            if (hit(wb_adr_i, IDX_START) && s_reg.dma_en && s_reg.xfr == XF_IDLE) begin
                s_next.xfr       = XF_WAIT;
                s_next.eot_seen  = 1'b0;
                s_next.hold_full = 1'b0;
                s_next.last_sent = 1'b0;
            end
            // write one to clear; a fresh event in the same cycle wins
            if (hit(wb_adr_i, IDX_IRQ)) begin
                if (wb_dat_i[IRQ_MM_BIT] && !(mm_now && !s_reg.mm_q)) begin
                    s_next.irq_mm = 1'b0;
                end
                if (wb_dat_i[IRQ_RSL_BIT] && !(sel_in && !bsy_in && phase_in[0] &&
                                                |(data_in & s_reg.own_id))) begin
                    s_next.irq_rsl = 1'b0;
                end
            end
        end

        // ---------------- register reads ----------------
        s_next.wb_dat = 8'h00;
        if (wb_req && !wb_we_i) begin
            if (hit(wb_adr_i, IDX_DATA)) begin
                s_next.wb_dat = s_reg.own_id;
            end
            if (hit(wb_adr_i, IDX_STATUS)) begin
                s_next.wb_dat[ST_AIP_BIT] = s_reg.aip;
                s_next.wb_dat[5:0]        = {phase_in, req_in, sel_in, bsy_in};
            end
            if (hit(wb_adr_i, IDX_MODE)) begin
                s_next.wb_dat[MD_ARB_BIT]  = s_reg.arbitrate;
                s_next.wb_dat[MD_DMA_BIT]  = s_reg.dma_en;
                s_next.wb_dat[MD_BLK_BIT]  = s_reg.blockmode;
                s_next.wb_dat[MD_SEND_BIT] = s_reg.send;
                s_next.wb_dat[MD_LOST_BIT] = s_reg.lost;
            end
            if (hit(wb_adr_i, IDX_TCMD)) begin
                s_next.wb_dat[2:0]         = s_reg.phase_exp;
                s_next.wb_dat[TC_LAST_BIT] = s_reg.last_sent;
            end
            if (hit(wb_adr_i, IDX_IRQ)) begin
                s_next.wb_dat[IRQ_MM_BIT]  = s_reg.irq_mm;
                s_next.wb_dat[IRQ_RSL_BIT] = s_reg.irq_rsl;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= ST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o      = s_reg.wb_ack;
    assign wb_dat_o      = {24'h000000, s_reg.wb_dat};
    assign bsy_out       = 1'b0;
    assign bsy_oe_n      = !s_reg.bsy_drv;
    assign ack_out       = 1'b0;
    assign ack_oe_n      = !s_reg.ack_drv;
    assign data_out      = s_reg.out_data;
    // mismatch forces data drivers off while transferring
    assign data_oe_n     = !(s_reg.data_drv && (s_reg.arb == ARB_DRIVE || phase_ok));
    assign host_data_out = s_reg.hold;
    assign dma_request_out = s_reg.xfr != XF_IDLE && !s_reg.eot_seen &&
                             (s_reg.send ? !s_reg.hold_full : s_reg.hold_full);

    // ready only throttles in blockmode; idle or stopped engine never stalls the cpu bus
    always_comb begin
        if (!s_reg.blockmode || s_reg.xfr == XF_IDLE) begin
            ready_out = 1'b1;
        end else if (s_reg.send) begin
            // stall while held byte is untransferred
            // high again once final byte left
            ready_out = !s_reg.hold_full;
        end else begin
            // end of transfer releases the read at once
            ready_out = s_reg.hold_full || (end_of_transfer_input && dma_acknowledge_in);
        end
    end

    // ---------------- checks ----------------
    logic [CNT_W-1:0] idle_cnt;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt <= '0;
        end else if (!bus_idle || s_reg.arb == ARB_IDLE) begin
            // bus free only counts while arbitration is requested
            idle_cnt <= '0;
        end else if (idle_cnt != '1) begin
            idle_cnt <= idle_cnt + CNT_W'(1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_arb_drive_id: assert property (s_reg.arb == ARB_DRIVE |->
        !bsy_oe_n && !data_oe_n && data_out == s_reg.own_id && s_reg.aip)
        else $error("arbitration not driving BSY and own id");
    a_arb_window: assert property ($rose(s_reg.arb == ARB_DRIVE) |->
        idle_cnt >= CNT_W'(ARB_MIN_CYC - 1) && idle_cnt <= CNT_W'(ARB_MAX_CYC))
        else $error("arbitration asserted outside its window");
    a_free_qual: assert property ($rose(s_reg.arb == ARB_DELAY) |->
        idle_cnt >= CNT_W'(BUS_FREE_MIN_NS / CLK_NS) && idle_cnt <= CNT_W'(BUS_FREE_MAX_NS / CLK_NS))
        else $error("bus free qualified with wrong interval");
    a_sel_release: assert property (s_reg.arb == ARB_DRIVE && sel_in && s_reg.arbitrate |=>
        bsy_oe_n && data_oe_n && s_reg.lost)
        else $error("drivers not released after SEL");
    a_bsy_release: assert property ((!bsy_in && s_reg.arb == ARB_IDLE) [*2] |-> data_oe_n)
        else $error("data driven with BSY false");
    a_req_clear: assert property (!s_reg.arbitrate ##1 !s_reg.arbitrate |->
        !s_reg.aip && !s_reg.lost && bsy_oe_n)
        else $error("arbitration flags survive request clear");
    a_hold_keep: assert property (s_reg.send && s_reg.hold_full && s_reg.xfr != XF_IDLE |=>
        $stable(s_reg.hold) || !$past(s_reg.hold_full))
        else $error("held byte overwritten");
    a_ready_send: assert property (s_reg.blockmode && s_reg.send && s_reg.hold_full &&
        s_reg.xfr != XF_IDLE |-> !ready_out)
        else $error("ready true with untransferred byte");
    a_eot_recv: assert property (s_reg.blockmode && !s_reg.send && s_reg.xfr != XF_IDLE &&
        end_of_transfer_input && dma_acknowledge_in |-> ready_out)
        else $error("ready not asserted on receive end of transfer");
    a_last_sent: assert property (s_reg.xfr == XF_ACK && s_reg.send && s_reg.eot_seen &&
        !req_in |=> s_reg.last_sent && s_reg.xfr == XF_IDLE && ack_oe_n)
        else $error("last byte not flagged or ack kept");
    a_mm_latch: assert property (mm_now && !s_reg.mm_q |=> s_reg.irq_mm)
        else $error("phase mismatch not latched");
    a_dma_bsy: assert property ($rose(s_reg.dma_en) |-> $past(bsy_in))
        else $error("dma enable set without BSY");

    c_arb_won: cover property (s_reg.arb == ARB_DRIVE [*8]);
    c_arb_lost: cover property ($rose(s_reg.lost));
    c_send_eot: cover property ($rose(s_reg.last_sent));
    c_mismatch: cover property ($rose(s_reg.irq_mm));

endmodule : sadt_core
`default_nettype wire

// [tb/sadt_target.sv]
// target model on the far side of the scsi bus
`timescale 1ns/1ps
`default_nettype none
module sadt_target (
    input  wire logic       clock,
    input  wire logic       hold_bsy,
    input  wire logic       win_sel,
    input  wire logic       serve,
    input  wire logic [7:0] bus_byte,
    input  wire logic       ack_oe_n,
    output logic            bsy_in,
    output logic            sel_in,
    output logic            req_in,
    output logic [7:0]      data_in
);
    assign bsy_in  = hold_bsy;
    assign sel_in  = win_sel;
    // released lines sit at their inactive pulled level
    assign data_in = (serve || win_sel) ? bus_byte : 8'h00;
    // req falls once ack is seen, rises again after ack is released
    always @(posedge clock) begin
        req_in <= serve & ack_oe_n;
    end
endmodule : sadt_target
`default_nettype wire

// [tb/sadt_core_test.sv]
// self-checking bench for the arbitration and dma block
`timescale 1ns/1ps
`default_nettype none
module sadt_core_test;
    import sadt_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, host_data_in = 8'h00, bus_byte = 8'h5a;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, rdat;
    logic [2:0] phase_in = 3'h0;
    logic hold_bsy = 1'b0, win_sel = 1'b0, serve = 1'b0, host_read_strobe = 1'b0;
    logic dma_acknowledge_in = 1'b0, host_write_strobe = 1'b0, end_of_transfer_input = 1'b0;
    wire [31:0] wb_dat_o;
    wire [7:0] data_in, data_out, host_data_out;
    wire wb_ack_o, bsy_in, sel_in, req_in, bsy_oe_n, ack_oe_n, data_oe_n, dma_request_out, ready_out;
    wire bsy_out, ack_out;
    int n_mismatch = 0;
    int comparisons = 0;
    always #2.5 clock = ~clock;
    sadt_core dut_u (.clock, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .bsy_in, .sel_in, .req_in, .phase_in, .data_in, .bsy_out, .bsy_oe_n,
        .ack_out, .ack_oe_n, .data_out, .data_oe_n, .dma_acknowledge_in, .host_read_strobe,
        .host_write_strobe, .end_of_transfer_input, .host_data_in, .host_data_out, .dma_request_out,
        .ready_out);
    sadt_target far_u (.clock, .hold_bsy, .win_sel, .serve, .bus_byte, .ack_oe_n, .bsy_in, .sel_in, .req_in,
        .data_in);
    task automatic complete_run;
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (wb_ack_o !== 1'b1) n_mismatch++;
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        check("register", rdat, {24'h0, e});
    endtask : rd
    task automatic wait_ack(input logic v);
        for (int i = 0; i < 50 && ack_oe_n !== v; i++) @(posedge clock);
    endtask : wait_ack
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end
    initial begin
        int n;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        wb(1'b1, 8'h00, 8'h42);
        wb(1'b1, 8'h08, 8'h01);
        n = 0;
        while (bsy_oe_n !== 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        check("arb delay", 32'(n >= ARB_MIN_CYC && n <= ARB_MAX_CYC), 32'h1);
        check("own id", 32'(data_out), 32'h42);
        check("pin level", 32'({bsy_out, ack_out}), 32'h0);
        rd(8'h04, 8'h40);
        // host lets one arbitration delay pass
        repeat (ARB_MAX_CYC) @(posedge clock);
        win_sel <= 1'b1;
        repeat (2) @(posedge clock);
        check("release", 32'({bsy_oe_n, data_oe_n}), 32'h3);
        rd(8'h08, 8'h81);
        win_sel <= 1'b0;
        wb(1'b1, 8'h08, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h04, 8'h00);
        wb(1'b1, 8'h08, 8'h0e);
        rd(8'h08, 8'h0c);
        hold_bsy <= 1'b1;
        wb(1'b1, 8'h08, 8'h0e);
        rd(8'h08, 8'h0e);
        wb(1'b1, 8'h0c, 8'h00);
        wb(1'b1, 8'h10, 8'h00);
        check("dma request", 32'(dma_request_out), 32'h1);
        // end of transfer rides with the last strobe
        {dma_acknowledge_in, host_write_strobe, end_of_transfer_input} <= 3'h7;
        host_data_in <= 8'ha5;
        repeat (2) @(posedge clock);
        {dma_acknowledge_in, host_write_strobe, end_of_transfer_input} <= 3'h0;
        @(posedge clock);
        check("ready held", 32'(ready_out), 32'h0);
        check("request off", 32'(dma_request_out), 32'h0);
        serve <= 1'b1;
        wait_ack(1'b0);
        check("bus byte", 32'({data_oe_n, data_out}), 32'h0a5);
        serve <= 1'b0;
        wait_ack(1'b1);
        check("ack off", 32'(ack_oe_n), 32'h1);
        check("ready back", 32'(ready_out), 32'h1);
        rd(8'h0c, 8'h80);
        rd(8'h08, 8'h0e);
        serve <= 1'b1;
        repeat (20) @(posedge clock);
        check("idle engine", 32'(ack_oe_n), 32'h1);
        wb(1'b1, 8'h0c, 8'h01);
        rd(8'h14, 8'h01);
        wb(1'b1, 8'h08, 8'h0c);
        wb(1'b1, 8'h14, 8'h01);
        rd(8'h14, 8'h00);
        wb(1'b1, 8'h08, 8'h0e);
        rd(8'h14, 8'h01);
        serve <= 1'b0;
        wb(1'b1, 8'h0c, 8'h00);
        wb(1'b1, 8'h08, 8'h06);
        wb(1'b1, 8'h10, 8'h00);
        check("ready empty", 32'(ready_out), 32'h0);
        serve <= 1'b1;
        wait_ack(1'b0);
        serve <= 1'b0;
        wait_ack(1'b1);
        check("rx byte", 32'({dma_request_out, host_data_out}), 32'h15a);
        // end of transfer with the read of the last byte
        {dma_acknowledge_in, host_read_strobe, end_of_transfer_input} <= 3'h7;
        @(posedge clock);
        check("ready eot", 32'(ready_out), 32'h1);
        {dma_acknowledge_in, host_read_strobe, end_of_transfer_input} <= 3'h0;
        @(posedge clock);
        check("rx idle", 32'(dma_request_out), 32'h0);
        // reselection seen, then phase bits disagree with the bus
        hold_bsy <= 1'b0;
        win_sel <= 1'b1;
        phase_in <= 3'h1;
        repeat (2) @(posedge clock);
        win_sel <= 1'b0;
        wb(1'b1, 8'h0c, 8'h06);
        rd(8'h14, 8'h03);
        complete_run();
    end
endmodule : sadt_core_test
`default_nettype wire
